// ==== core/ccpc_pkg.sv ====
// Shared constants for the compare/PWM pin control unit
package ccpc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_UNIT_CONTROL  = 8'h00;
    localparam logic [7:0] OFS_CMP_LOW       = 8'h04;
    localparam logic [7:0] OFS_CMP_HIGH      = 8'h08;
    localparam logic [7:0] OFS_PIN_CONFIG    = 8'h0C;
    localparam logic [7:0] OFS_INT_STATUS    = 8'h10;
    localparam logic [7:0] OFS_INT_MASK      = 8'h14;
    localparam logic [7:0] OFS_PWM_PERIOD    = 8'h18;

    // Reset values
    localparam logic [7:0] RST_UNIT_CONTROL  = 8'h00;
    localparam logic [7:0] RST_CMP_BYTE      = 8'h00;
    localparam logic [1:0] RST_PIN_CONFIG    = 2'h1;
    localparam logic [1:0] RST_INT_STATUS    = 2'h0;
    localparam logic [1:0] RST_INT_MASK      = 2'h0;
    localparam logic [7:0] RST_PWM_PERIOD    = 8'hFF;

    // Field positions
    localparam int MODE_LSB       = 0;
    localparam int DUTY_LOW_LSB   = 4;
    localparam int PIN_DIR_BIT    = 0;
    localparam int PIN_ALT_BIT    = 1;
    localparam int ST_MATCH_BIT   = 0;
    localparam int ST_TRIGGER_BIT = 1;

    // Values of the unit_mode_field
    localparam logic [3:0] MODE_OFF      = 4'h0;
    localparam logic [3:0] MODE_TOGGLE   = 4'h2;
    localparam logic [3:0] MODE_SET      = 4'h8;
    localparam logic [3:0] MODE_CLEAR    = 4'h9;
    localparam logic [3:0] MODE_SWINT    = 4'hA;
    localparam logic [3:0] MODE_SPECIAL  = 4'hB;
    localparam logic [1:0] MODE_PWM_TOP  = 2'h3;

    // Unit instance that may start the converter
    localparam int ADC_UNIT_INDEX = 5;
endpackage : ccpc_pkg

// ==== core/ccpc_match.sv ====
// 16-bit equality detector with first-cycle hit pulse
`timescale 1ns/1ps
module ccpc_match #(
    parameter int WIDTH = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             enable,
    input  wire logic [WIDTH-1:0] compare_value,
    input  wire logic [WIDTH-1:0] timer_count,
    output logic                  equal,
    output logic                  hit
);
    logic equal_prev_q;

    assign equal = enable && (compare_value == timer_count);
    // Only the first cycle of an equal run counts as a match
    assign hit   = equal && !equal_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            equal_prev_q <= 1'b0;
        end else begin
            equal_prev_q <= equal;
        end
    end
endmodule : ccpc_match

// ==== core/ccpc_pwm.sv ====
// Standard PWM generator with 10-bit time base and double-buffered duty
`timescale 1ns/1ps
module ccpc_pwm #(
    parameter int PERIOD_W = 8,
    parameter int FRAC_W   = 2
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         enable,
    input  wire logic [PERIOD_W-1:0]          period,
    input  wire logic [PERIOD_W+FRAC_W-1:0]   duty,
    output logic [PERIOD_W+FRAC_W-1:0]        duty_latched,
    output logic                              pwm_out
);
    localparam int TB_W = PERIOD_W + FRAC_W;

    logic [TB_W-1:0] base_q;
    logic [TB_W-1:0] duty_q;
    logic            out_q;
    wire             period_end = (base_q[TB_W-1:FRAC_W] == period) && (&base_q[FRAC_W-1:0]);
    wire [TB_W-1:0]  base_next  = base_q + 1'b1;
    // Clear one step early so the registered pin stays high for exactly duty steps
    wire             duty_hit   = (base_next == duty_q);

    assign duty_latched = duty_q;
    assign pwm_out      = out_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_q <= '0;
            duty_q <= '0;
            out_q  <= 1'b0;
        end else if (!enable) begin
            base_q <= '0;
            out_q  <= 1'b0;
        end else if (period_end) begin
            base_q <= '0;
            duty_q <= duty;
            out_q  <= (duty != '0);
        end else begin
            base_q <= base_q + 1'b1;
            if (duty_hit) begin
                out_q <= 1'b0;
            end
        end
    end
endmodule : ccpc_pwm

// ==== core/ccpc_top.sv ====
// Compare unit with pin control, special event trigger, PWM and APB registers
`timescale 1ns/1ps
module ccpc_top
    import ccpc_pkg::*;
#(
    parameter int UNIT_INDEX = ADC_UNIT_INDEX
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  timer1_count_high,
    input  wire logic [7:0]  timer1_count_low,
    input  wire logic        timer1_tick,
    output logic             timer1_reset,
    input  wire logic        adc_enabled,
    output logic             adc_start,
    input  wire logic        sleep_mode,
    output logic             special_trigger,
    output logic             pin_main_out,
    output logic             pin_main_oe_n,
    output logic             pin_alt_out,
    output logic             pin_alt_oe_n,
    output logic             irq
);
    // Register state
    logic [7:0]  unit_control_q;
    logic [7:0]  cmp_low_q;
    logic [7:0]  cmp_high_q;
    logic [1:0]  pin_config_q;
    logic [1:0]  int_status_q;
    logic [1:0]  int_status_d;
    logic [1:0]  int_mask_q;
    logic [7:0]  pwm_period_q;
    logic [31:0] prdata_q;
    logic        cmp_latch_q;
    logic        cmp_latch_d;
    logic        reset_pending_q;

    // Bus decode
    wire         setup_phase = psel && !penable;
    wire         access      = psel && penable;
    wire         wr          = access && pwrite;
    wire         rd_setup    = setup_phase && !pwrite;
    wire         sel_ctrl    = (paddr == OFS_UNIT_CONTROL);
    wire         sel_low     = (paddr == OFS_CMP_LOW);
    wire         sel_high    = (paddr == OFS_CMP_HIGH);
    wire         sel_pin     = (paddr == OFS_PIN_CONFIG);
    wire         sel_stat    = (paddr == OFS_INT_STATUS);
    wire         sel_mask    = (paddr == OFS_INT_MASK);
    wire         sel_period  = (paddr == OFS_PWM_PERIOD);
    wire         mapped      = sel_ctrl || sel_low || sel_high || sel_pin || sel_stat || sel_mask || sel_period;
    wire         ctrl_zero_wr = wr && sel_ctrl && (pwdata[7:0] == 8'h00);

    // Mode decode
    wire [3:0]   mode        = unit_control_q[MODE_LSB +: 4];
    wire         mode_pwm    = (mode[3:2] == MODE_PWM_TOP);
    wire         mode_toggle = (mode == MODE_TOGGLE);
    wire         mode_set    = (mode == MODE_SET);
    wire         mode_clear  = (mode == MODE_CLEAR);
    wire         mode_swint  = (mode == MODE_SWINT);
    wire         mode_special = (mode == MODE_SPECIAL);
    wire         mode_compare = mode_toggle || mode_set || mode_clear || mode_swint || mode_special;

    // Compare core
    wire         cmp_equal;
    wire         cmp_hit;
    wire [15:0]  cmp_value   = {cmp_high_q, cmp_low_q};
    wire [15:0]  timer_value = {timer1_count_high, timer1_count_low};

    ccpc_match #(
        .WIDTH         (16)
    ) u_match (
        .pclk          (pclk),
        .presetn       (presetn),
        .enable        (mode_compare && !sleep_mode),
        .compare_value (cmp_value),
        .timer_count   (timer_value),
        .equal         (cmp_equal),
        .hit           (cmp_hit)
    );

    // PWM generator
    wire [9:0]   pwm_duty_latched;
    wire         pwm_wave;

    ccpc_pwm #(
        .PERIOD_W     (8),
        .FRAC_W       (2)
    ) u_pwm (
        .pclk         (pclk),
        .presetn      (presetn),
        .enable       (mode_pwm),
        .period       (pwm_period_q),
        .duty         ({cmp_low_q, unit_control_q[DUTY_LOW_LSB +: 2]}),
        .duty_latched (pwm_duty_latched),
        .pwm_out      (pwm_wave)
    );

    // Trigger fires combinationally in the match cycle; it feeds the Timer1
    // reset path, the converter and the trigger status flag
    assign special_trigger = mode_special && cmp_hit;
    assign adc_start       = special_trigger && adc_enabled && (UNIT_INDEX == ADC_UNIT_INDEX);
    // Reset waits for the Timer1 edge and needs the match to still hold
    assign timer1_reset    = reset_pending_q && timer1_tick && cmp_equal;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_pending_q <= 1'b0;
        end else if (special_trigger) begin
            reset_pending_q <= 1'b1;
        end else if (timer1_tick || !cmp_equal) begin
            reset_pending_q <= 1'b0;
        end
    end

    // Compare output latch
    always_comb begin
        cmp_latch_d = cmp_latch_q;
        if (cmp_hit && mode_set) begin
            cmp_latch_d = 1'b1;
        end else if (cmp_hit && mode_clear) begin
            cmp_latch_d = 1'b0;
        end else if (cmp_hit && mode_toggle) begin
            cmp_latch_d = !cmp_latch_q;
        end
        if (ctrl_zero_wr) begin
            cmp_latch_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_latch_q <= 1'b0;
        end else begin
            cmp_latch_q <= cmp_latch_d;
        end
    end

    // Pin ownership and routing
    wire         pin_owned   = mode_toggle || mode_set || mode_clear || mode_pwm;
    wire         pin_drive   = pin_owned && !pin_config_q[PIN_DIR_BIT];
    wire         pin_level   = mode_pwm ? pwm_wave : cmp_latch_q;
    wire         use_alt     = pin_config_q[PIN_ALT_BIT];

    assign pin_main_out  = pin_level && !use_alt;
    assign pin_alt_out   = pin_level && use_alt;
    assign pin_main_oe_n = !(pin_drive && !use_alt);
    assign pin_alt_oe_n  = !(pin_drive && use_alt);

    // Interrupt status: hardware set wins over read clear
    wire [1:0]   int_events  = {special_trigger, cmp_hit};
    wire         stat_rd_clr = access && !pwrite && sel_stat;
    // Only bits reported by this read are cleared, so a late event survives
    wire [1:0]   stat_clr    = stat_rd_clr ? prdata_q[1:0] : 2'b00;

    always_comb begin
        int_status_d = (int_status_q & ~stat_clr) | int_events;
    end

    assign irq = |(int_status_q & int_mask_q);

    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_control_q <= RST_UNIT_CONTROL;
            cmp_low_q      <= RST_CMP_BYTE;
            cmp_high_q     <= RST_CMP_BYTE;
            pin_config_q   <= RST_PIN_CONFIG;
            int_mask_q     <= RST_INT_MASK;
            pwm_period_q   <= RST_PWM_PERIOD;
            int_status_q   <= RST_INT_STATUS;
        end else begin
            int_status_q <= int_status_d;
            if (wr && sel_ctrl) begin
                unit_control_q <= pwdata[7:0];
            end
            if (wr && sel_low) begin
                cmp_low_q <= pwdata[7:0];
            end
            if (wr && sel_high && !mode_pwm) begin
                cmp_high_q <= pwdata[7:0];
            end
            if (wr && sel_pin) begin
                pin_config_q <= pwdata[1:0];
            end
            if (wr && sel_mask) begin
                int_mask_q <= pwdata[1:0];
            end
            if (wr && sel_period) begin
                pwm_period_q <= pwdata[7:0];
            end
        end
    end

    // Read data, captured in the setup cycle
    wire [7:0]   high_view = mode_pwm ? pwm_duty_latched[9:2] : cmp_high_q;
    wire [31:0]  rd_mux    = sel_ctrl   ? {24'h000000, unit_control_q} :
                             sel_low    ? {24'h000000, cmp_low_q} :
                             sel_high   ? {24'h000000, high_view} :
                             sel_pin    ? {30'h0000000, pin_config_q} :
                             sel_stat   ? {30'h0000000, int_status_q} :
                             sel_mask   ? {30'h0000000, int_mask_q} :
                             sel_period ? {24'h000000, pwm_period_q} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_q <= rd_mux;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_trig_same_cycle: assert property (mode_special && cmp_equal && !$past(cmp_equal) && !sleep_mode
        |-> special_trigger) else $error("special trigger late");
    a_swint_no_pin: assert property (mode_swint |-> pin_main_oe_n && pin_alt_oe_n)
        else $error("pin driven in software interrupt mode");
    a_special_no_pin: assert property (mode_special |-> pin_main_oe_n && pin_alt_oe_n)
        else $error("pin driven in special trigger mode");
    a_ctrl_clear_latch: assert property (ctrl_zero_wr |=> !cmp_latch_q && pin_main_oe_n && pin_alt_oe_n)
        else $error("zero control write left latch or pin");
    a_pwm_release: assert property (mode_pwm && ctrl_zero_wr |=> pin_main_oe_n && pin_alt_oe_n)
        else $error("pin kept after zero control write in pwm");
    a_flag_on_match: assert property (cmp_hit |=> int_status_q[ST_MATCH_BIT])
        else $error("match flag not set");
    a_reset_needs_match: assert property (timer1_reset |-> cmp_equal && timer1_tick
        && $past(special_trigger || reset_pending_q)) else $error("timer reset without live match");
    a_reset_cancel: assert property (special_trigger ##1 !cmp_equal |-> !timer1_reset)
        else $error("timer reset after lost match");
    a_adc_gate: assert property (adc_start |-> special_trigger && adc_enabled)
        else $error("converter start without enabled trigger");
    a_set_latch: assert property (mode_set && cmp_hit && !ctrl_zero_wr |=> cmp_latch_q)
        else $error("set mode did not raise latch");
    a_sleep_quiet: assert property (sleep_mode |-> !special_trigger && !cmp_hit)
        else $error("match while asleep");

    // Latch, match, routing, register, flag and trigger checks
    a_clear_latch: assert property (mode_clear && cmp_hit && !ctrl_zero_wr |=> !cmp_latch_q)
        else $error("clear mode did not lower latch");
    a_toggle_latch: assert property (mode_toggle && cmp_hit && !ctrl_zero_wr
        |=> cmp_latch_q != $past(cmp_latch_q)) else $error("toggle mode did not invert latch");
    a_latch_hold: assert property (!cmp_hit && !ctrl_zero_wr |=> $stable(cmp_latch_q))
        else $error("latch moved without a match");
    a_trig_flag: assert property (special_trigger |=> int_status_q[ST_TRIGGER_BIT])
        else $error("trigger flag not set");
    a_single_match: assert property (cmp_hit |=> !cmp_hit)
        else $error("held equal count matched twice");
    a_no_match_off: assert property (!mode_compare |-> !cmp_hit)
        else $error("match outside compare modes");
    a_pin_input: assert property (pin_config_q[PIN_DIR_BIT] |-> pin_main_oe_n && pin_alt_oe_n)
        else $error("pin driven while direction is input");
    a_one_pin: assert property (!pin_main_oe_n |-> pin_alt_oe_n)
        else $error("both pins driven");
    a_duty_read_only: assert property (mode_pwm && wr && sel_high |=> $stable(cmp_high_q))
        else $error("compare high written in pwm mode");
    a_trig_pending: assert property (special_trigger |=> reset_pending_q)
        else $error("trigger did not arm timer reset");
    a_reset_once: assert property (timer1_reset |=> !reset_pending_q)
        else $error("timer reset armed after firing");
    a_adc_fire: assert property (special_trigger && adc_enabled && (UNIT_INDEX == ADC_UNIT_INDEX)
        |-> adc_start) else $error("enabled trigger did not start converter");
    a_irq_level: assert property ((|(int_status_q & int_mask_q)) |-> irq)
        else $error("unmasked flag without interrupt");

    c_special_reset: cover property (special_trigger ##[1:20] timer1_reset);
    c_toggle_twice: cover property (mode_toggle && cmp_hit ##[1:200] mode_toggle && cmp_hit);
    c_pwm_pin: cover property (mode_pwm && !pin_main_oe_n && pin_main_out);
    c_irq: cover property (irq ##1 stat_rd_clr);
    c_pwm_high_write: cover property (mode_pwm && wr && sel_high);
endmodule : ccpc_top

// ==== tb/ccpc_timer1_model.sv ====
// Timer1 counter and converter-start model on the far side of the compare unit
`timescale 1ns/1ps
module ccpc_timer1_model #(
    parameter int TICK_DIV = 8
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       restart,
    input  wire logic       timer1_reset,
    input  wire logic       adc_start,
    output logic [7:0]      timer1_count_high,
    output logic [7:0]      timer1_count_low,
    output logic            timer1_tick,
    output logic [7:0]      resets_seen,
    output logic [7:0]      adc_starts_seen
);
    logic [7:0]  div_q;
    logic [15:0] count_q;
    logic [7:0]  rst_q;
    logic [7:0]  adc_q;

    // Tick at a fraction of pclk, synchronous to it
    assign timer1_tick       = (div_q == 8'(TICK_DIV - 1));
    assign timer1_count_high = count_q[15:8];
    assign timer1_count_low  = count_q[7:0];
    assign resets_seen       = rst_q;
    assign adc_starts_seen   = adc_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 8'h00;
            count_q <= 16'h0000;
            rst_q <= 8'h00;
        end else if (restart) begin
            div_q <= 8'h00;
            count_q <= 16'h0000;
        end else begin
            div_q <= timer1_tick ? 8'h00 : div_q + 8'h01;
            // Clear only when the request coincides with a tick
            if (timer1_tick && timer1_reset) begin
                count_q <= 16'h0000;
                rst_q <= rst_q + 8'h01;
            end else if (timer1_tick) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_q <= 8'h00;
        end else if (adc_start) begin
            adc_q <= adc_q + 8'h01;
        end
    end
endmodule : ccpc_timer1_model

// ==== tb/ccp_compare_and_pwm_pin_control_test.sv ====
// Self-checking bench for the compare unit over APB with a Timer1 model
`timescale 1ns/1ps
module ccp_compare_and_pwm_pin_control_test
    import ccpc_pkg::*;
;
    localparam logic [15:0] CMPV = 16'h0008;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  cnt_hi, cnt_lo, n_rst, n_adc, rc0, ac0;
    logic        tick, tmr_rst, adc_enabled, adc_start, sleep_mode, special_trigger, irq, restart, e, trig_seen;
    logic        pin_main_out, pin_main_oe_n, pin_alt_out, pin_alt_oe_n;
    int          n_fail = 0;
    int          checks_done = 0;
    int          k, hi;
    logic [7:0]  ra [6] = '{OFS_UNIT_CONTROL, OFS_CMP_LOW, OFS_CMP_HIGH, OFS_PIN_CONFIG, OFS_INT_STATUS, OFS_PWM_PERIOD};
    logic [31:0] rv [6] = '{32'(RST_UNIT_CONTROL), 32'(RST_CMP_BYTE), 32'(RST_CMP_BYTE), 32'(RST_PIN_CONFIG),
                            32'(RST_INT_STATUS), 32'(RST_PWM_PERIOD)};
    logic [3:0]  md [5] = '{MODE_SET, MODE_CLEAR, MODE_TOGGLE, MODE_TOGGLE, MODE_SET};
    logic        pe [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    always #20 pclk = ~pclk;

    ccpc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer1_count_high(cnt_hi),
        .timer1_count_low(cnt_lo), .timer1_tick(tick), .timer1_reset(tmr_rst), .adc_enabled(adc_enabled),
        .adc_start(adc_start), .sleep_mode(sleep_mode), .special_trigger(special_trigger),
        .pin_main_out(pin_main_out), .pin_main_oe_n(pin_main_oe_n), .pin_alt_out(pin_alt_out),
        .pin_alt_oe_n(pin_alt_oe_n), .irq(irq));

    ccpc_timer1_model #(.TICK_DIV(8)) tmr (.pclk(pclk), .presetn(presetn), .restart(restart),
        .timer1_reset(tmr_rst), .adc_start(adc_start), .timer1_count_high(cnt_hi), .timer1_count_low(cnt_lo),
        .timer1_tick(tick), .resets_seen(n_rst), .adc_starts_seen(n_adc));

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 16) begin
            $display("ERROR pready expected 1 seen %b", pready);
            n_fail++;
            tally_and_finish();
        end
    endtask : apb

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, q);
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle

    // Zero the timer, select the mode, then wait for the first equal cycle
    task automatic hit(input logic [3:0] m);
        int i;
        @(posedge pclk);
        restart <= 1'b1;
        @(posedge pclk);
        restart <= 1'b0;
        apb(1'b1, OFS_UNIT_CONTROL, 32'(m));
        #1;
        i = 0;
        while ({cnt_hi, cnt_lo} !== CMPV && i < 4000) begin
            settle(1);
            i++;
        end
        trig_seen = special_trigger;
        if (i >= 4000) begin
            $display("ERROR timer count expected %h seen %h", CMPV, {cnt_hi, cnt_lo});
            n_fail++;
            tally_and_finish();
        end
    endtask : hit

    initial begin
        {presetn, psel, penable, pwrite, restart, adc_enabled, sleep_mode} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 6; k++) rd("reset value", ra[k], rv[k]);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped data", 32'h0, q);
        chk("unmapped error", 32'h1, 32'(e));
        apb(1'b1, OFS_UNIT_CONTROL, 32'h000000F0);
        rd("control", OFS_UNIT_CONTROL, 32'h000000F0);
        apb(1'b1, OFS_CMP_LOW, 32'(CMPV[7:0]));
        apb(1'b1, OFS_CMP_HIGH, 32'(CMPV[15:8]));
        rd("compare low", OFS_CMP_LOW, 32'(CMPV[7:0]));
        apb(1'b1, OFS_PIN_CONFIG, 32'h0);
        for (k = 0; k < 5; k++) begin
            hit(md[k]);
            settle(3);
            chk("pin level", 32'(pe[k]), 32'(pin_main_out));
            chk("pin driven", 32'h0, 32'(pin_main_oe_n));
        end
        apb(1'b1, OFS_UNIT_CONTROL, 32'h0);
        settle(2);
        chk("latch cleared", 32'h0, 32'(pin_main_out));
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, OFS_INT_MASK, 32'h3);
        settle(1);
        chk("irq raised", 32'h1, 32'(irq));
        rd("status", OFS_INT_STATUS, 32'h1);
        settle(1);
        chk("irq cleared", 32'h0, 32'(irq));
        rd("status cleared", OFS_INT_STATUS, 32'h0);
        apb(1'b1, OFS_PIN_CONFIG, 32'h2);
        hit(MODE_SET);
        settle(3);
        chk("alt level", 32'h1, 32'(pin_alt_out));
        chk("alt driven", 32'h0, 32'(pin_alt_oe_n));
        chk("main released", 32'h1, 32'(pin_main_oe_n));
        rd("status", OFS_INT_STATUS, 32'h1);
        hit(MODE_SWINT);
        settle(3);
        chk("alt released", 32'h1, 32'(pin_alt_oe_n));
        rd("status", OFS_INT_STATUS, 32'h1);
        apb(1'b1, OFS_PIN_CONFIG, 32'h0);
        @(posedge pclk);
        adc_enabled <= 1'b1;
        rc0 = n_rst;
        ac0 = n_adc;
        hit(MODE_SPECIAL);
        chk("trigger in match cycle", 32'h1, 32'(trig_seen));
        settle(13);
        chk("timer resets", 32'(rc0 + 8'h01), 32'(n_rst));
        chk("adc starts", 32'(ac0 + 8'h01), 32'(n_adc));
        chk("pin not taken", 32'h1, 32'(pin_main_oe_n));
        apb(1'b1, OFS_UNIT_CONTROL, 32'h0);
        rd("status", OFS_INT_STATUS, 32'h3);
        @(posedge pclk);
        adc_enabled <= 1'b0;
        rc0 = n_rst;
        ac0 = n_adc;
        hit(MODE_SPECIAL);
        apb(1'b1, OFS_CMP_LOW, 32'h20);
        settle(12);
        chk("trigger seen", 32'h1, 32'(trig_seen));
        chk("reset withdrawn", 32'(rc0), 32'(n_rst));
        chk("adc disabled", 32'(ac0), 32'(n_adc));
        apb(1'b1, OFS_UNIT_CONTROL, 32'h0);
        apb(1'b1, OFS_CMP_LOW, 32'(CMPV[7:0]));
        apb(1'b0, OFS_INT_STATUS, 32'h0);
        @(posedge pclk);
        sleep_mode <= 1'b1;
        hit(MODE_SWINT);
        settle(3);
        rd("status asleep", OFS_INT_STATUS, 32'h0);
        @(posedge pclk);
        sleep_mode <= 1'b0;
        apb(1'b1, OFS_PWM_PERIOD, 32'h3);
        apb(1'b1, OFS_CMP_LOW, 32'h2);
        apb(1'b1, OFS_UNIT_CONTROL, 32'h0000000C);
        settle(40);
        hi = 0;
        repeat (32) begin
            settle(1);
            if (pin_main_out === 1'b1) hi++;
        end
        chk("pwm high cycles", 32'd16, 32'(hi));
        rd("duty latched", OFS_CMP_HIGH, 32'h2);
        apb(1'b1, OFS_CMP_HIGH, 32'h55);
        rd("duty read only", OFS_CMP_HIGH, 32'h2);
        chk("pwm pin driven", 32'h0, 32'(pin_main_oe_n));
        apb(1'b1, OFS_PIN_CONFIG, 32'h1);
        settle(1);
        chk("pin left input", 32'h1, 32'(pin_main_oe_n));
        apb(1'b1, OFS_PIN_CONFIG, 32'h0);
        settle(1);
        chk("pwm pin driven again", 32'h0, 32'(pin_main_oe_n));
        apb(1'b1, OFS_UNIT_CONTROL, 32'h0);
        settle(2);
        chk("pwm released", 32'h1, 32'(pin_main_oe_n));
        tally_and_finish();
    end
endmodule : ccp_compare_and_pwm_pin_control_test
